/* logic/ipr_map.svh */
// Register offsets, field positions and reset values of the priority bank
`ifndef IPR_MAP_SVH
`define IPR_MAP_SVH
`define IPR_OFF_LOW_VOLTAGE 4'h0
`define IPR_OFF_TIME_MEASURE 4'h1
`define IPR_OFF_UART3_GROUP 4'h2
`define IPR_OFF_UART4ERR_USB_I2C3 4'h3
`define IPR_OFF_SPI3_UART4 4'h4
`define IPR_OFF_CAPTURE9_COMPARE9 4'h5
`define IPR_POS_HI 12
`define IPR_POS_MH 8
`define IPR_POS_ML 4
`define IPR_POS_LO 0
`define IPR_FIELD_RESET 3'h4
`define IPR_LEVEL_OFF 3'h0
`define IPR_LEVEL_MAX 3'h7
`endif

/* logic/ipr_pkg.sv */
// Types shared by the priority bank
package ipr_pkg;
    typedef logic [2:0] ipr_level_type;
    typedef struct packed {
        ipr_level_type low_voltage_detect_prio;
        ipr_level_type time_measure_unit_prio;
        ipr_level_type uart3_transmit_prio;
        ipr_level_type uart3_receive_prio;
        ipr_level_type uart3_error_prio;
        ipr_level_type uart4_error_prio;
        ipr_level_type usb_otg_prio;
        ipr_level_type i2c3_master_event_prio;
        ipr_level_type i2c3_slave_event_prio;
        ipr_level_type spi3_event_prio;
        ipr_level_type spi3_fault_prio;
        ipr_level_type uart4_transmit_prio;
        ipr_level_type uart4_receive_prio;
        ipr_level_type capture_ch9_prio;
        ipr_level_type compare_ch9_prio;
    } ipr_prio_type;
    typedef struct packed {
        logic [14:0] pending;
    } ipr_flags_type;
endpackage

/* logic/ipr_bank.sv */
// Interrupt priority registers 18 to 23 with per-source request gating
//
// How it works
// - Field code 111 gives its source level 7, the highest user level.
// - Code 001 gives level 1; codes between give matching levels.
// - Code 000 disables its source; no request reaches arbitration.
// - Bits without a priority field read back as zero.
// - Fields are read/write; reset value is 100 in each field.
// - Register 18: low-voltage detect priority in bits 2-0.
// - Register 19: time measurement unit priority in bits 6-4.
// - Register 20: UART3 transmit 14-12, receive 10-8, error 6-4.
// - Register 21: UART4 error 14-12, USB OTG 10-8.
// - Register 21: I2C3 master event 6-4, slave event 2-0.
// - Register 22: SPI3 event 14-12, SPI3 fault 10-8.
// - Register 22: UART4 transmit 6-4, UART4 receive 2-0.
// - Register 23: capture ch9 6-4, compare ch9 2-0; rest unimplemented.
// - After reset every covered source sits at level 4.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ipr_map.svh"
module ipr_bank (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire ipr_pkg::ipr_flags_type src_flags,
    output ipr_pkg::ipr_prio_type prio_out,
    output logic [14:0] src_request
);
    import ipr_pkg::*;

    ipr_prio_type prio_q;
    logic [15:0] rdata_q;
    logic [15:0] rd_mux;

    function automatic logic [15:0] put(input ipr_level_type f,
                                        input int pos);
        put = 16'(f) << pos;
    endfunction

    function automatic ipr_level_type get(input logic [15:0] w,
                                          input int pos);
        get = ipr_level_type'(w >> pos);
    endfunction

    // Field storage; only the field bits exist, so stray bits are lost
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            prio_q <= {15{`IPR_FIELD_RESET}};
        end
        else if (reg_write)
        begin
            case (reg_addr)
                `IPR_OFF_LOW_VOLTAGE:
                begin
                    prio_q.low_voltage_detect_prio <=
                        get(reg_wdata, `IPR_POS_LO);
                end
                `IPR_OFF_TIME_MEASURE:
                begin
                    prio_q.time_measure_unit_prio <=
                        get(reg_wdata, `IPR_POS_ML);
                end
                `IPR_OFF_UART3_GROUP:
                begin
                    prio_q.uart3_transmit_prio <= get(reg_wdata, `IPR_POS_HI);
                    prio_q.uart3_receive_prio <= get(reg_wdata, `IPR_POS_MH);
                    prio_q.uart3_error_prio <= get(reg_wdata, `IPR_POS_ML);
                end
                `IPR_OFF_UART4ERR_USB_I2C3:
                begin
                    prio_q.uart4_error_prio <= get(reg_wdata, `IPR_POS_HI);
                    prio_q.usb_otg_prio <= get(reg_wdata, `IPR_POS_MH);
                    prio_q.i2c3_master_event_prio <=
                        get(reg_wdata, `IPR_POS_ML);
                    prio_q.i2c3_slave_event_prio <=
                        get(reg_wdata, `IPR_POS_LO);
                end
                `IPR_OFF_SPI3_UART4:
                begin
                    prio_q.spi3_event_prio <= get(reg_wdata, `IPR_POS_HI);
                    prio_q.spi3_fault_prio <= get(reg_wdata, `IPR_POS_MH);
                    prio_q.uart4_transmit_prio <= get(reg_wdata, `IPR_POS_ML);
                    prio_q.uart4_receive_prio <= get(reg_wdata, `IPR_POS_LO);
                end
                `IPR_OFF_CAPTURE9_COMPARE9:
                begin
                    prio_q.capture_ch9_prio <= get(reg_wdata, `IPR_POS_ML);
                    prio_q.compare_ch9_prio <= get(reg_wdata, `IPR_POS_LO);
                end
                default:
                begin
                    prio_q <= prio_q;
                end
            endcase
        end
    end

    // Read view; unimplemented bits and unmapped offsets give zero
    always_comb
    begin
        rd_mux = 16'h0000;
        case (reg_addr)
            `IPR_OFF_LOW_VOLTAGE:
                rd_mux = put(prio_q.low_voltage_detect_prio, `IPR_POS_LO);
            `IPR_OFF_TIME_MEASURE:
                rd_mux = put(prio_q.time_measure_unit_prio, `IPR_POS_ML);
            `IPR_OFF_UART3_GROUP:
                rd_mux = put(prio_q.uart3_transmit_prio, `IPR_POS_HI)
                    | put(prio_q.uart3_receive_prio, `IPR_POS_MH)
                    | put(prio_q.uart3_error_prio, `IPR_POS_ML);
            `IPR_OFF_UART4ERR_USB_I2C3:
                rd_mux = put(prio_q.uart4_error_prio, `IPR_POS_HI)
                    | put(prio_q.usb_otg_prio, `IPR_POS_MH)
                    | put(prio_q.i2c3_master_event_prio, `IPR_POS_ML)
                    | put(prio_q.i2c3_slave_event_prio, `IPR_POS_LO);
            `IPR_OFF_SPI3_UART4:
                rd_mux = put(prio_q.spi3_event_prio, `IPR_POS_HI)
                    | put(prio_q.spi3_fault_prio, `IPR_POS_MH)
                    | put(prio_q.uart4_transmit_prio, `IPR_POS_ML)
                    | put(prio_q.uart4_receive_prio, `IPR_POS_LO);
            `IPR_OFF_CAPTURE9_COMPARE9:
                rd_mux = put(prio_q.capture_ch9_prio, `IPR_POS_ML)
                    | put(prio_q.compare_ch9_prio, `IPR_POS_LO);
            default:
                rd_mux = 16'h0000;
        endcase
    end

    // Data is held only in the cycle after the read strobe
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rdata_q <= 16'h0000;
        end
        else if (reg_read)
        begin
            rdata_q <= rd_mux;
        end
        else
        begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
    // Level passes through as its own code, 0..7; 0 marks a disabled source
    assign prio_out = prio_q;

    // Zero level masks the flag before arbitration sees it
    always_comb
    begin
        for (int i = 0; i < 15; i++)
        begin
            src_request[i] = src_flags.pending[i]
                && (prio_q[i*3 +: 3] != `IPR_LEVEL_OFF);
        end
    end

    property p_disabled_quiet;
        @(posedge sys_clk) disable iff (sys_rst)
        (prio_q.compare_ch9_prio == `IPR_LEVEL_OFF) |-> !src_request[0];
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled source still requests");

    property p_enabled_passes;
        @(posedge sys_clk) disable iff (sys_rst)
        (prio_q.low_voltage_detect_prio != `IPR_LEVEL_OFF)
            |-> (src_request[14] == src_flags.pending[14]);
    endproperty
    a_enabled_passes: assert property (p_enabled_passes)
        else $error("enabled source request lost");

    property p_reset_level;
        @(posedge sys_clk)
        $past(sys_rst) |-> (prio_q == {15{`IPR_FIELD_RESET}});
    endproperty
    a_reset_level: assert property (p_reset_level)
        else $error("fields not at level 4 after reset");

    property p_max_level;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_LOW_VOLTAGE
            && reg_wdata[2:0] == `IPR_LEVEL_MAX)
            |=> (prio_out.low_voltage_detect_prio == `IPR_LEVEL_MAX);
    endproperty
    a_max_level: assert property (p_max_level)
        else $error("code 111 did not give level 7");

    property p_reg18_unimpl;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_read && reg_addr == `IPR_OFF_LOW_VOLTAGE)
            |=> (reg_rdata[15:3] == 13'h0000);
    endproperty
    a_reg18_unimpl: assert property (p_reg18_unimpl)
        else $error("unimplemented bits read nonzero");

    property p_reg23_unimpl;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_read && reg_addr == `IPR_OFF_CAPTURE9_COMPARE9)
            |=> (reg_rdata[15:7] == 9'h000 && !reg_rdata[3]);
    endproperty
    a_reg23_unimpl: assert property (p_reg23_unimpl)
        else $error("register 23 reserved bits nonzero");

    property p_readback;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_UART3_GROUP)
            ##1 (reg_read && reg_addr == `IPR_OFF_UART3_GROUP
                && !reg_write)
            |=> (reg_rdata == ($past(reg_wdata, 2) & 16'h7770));
    endproperty
    a_readback: assert property (p_readback)
        else $error("register 20 read back wrong");

    property p_rdata_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        !reg_read |=> (reg_rdata == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read cycle");

    property p_usb_field;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_UART4ERR_USB_I2C3)
            |=> (prio_out.usb_otg_prio == $past(reg_wdata[10:8]));
    endproperty
    a_usb_field: assert property (p_usb_field)
        else $error("usb field misplaced");

    property p_min_level;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_CAPTURE9_COMPARE9
            && reg_wdata[2:0] == 3'h1)
            |=> (prio_out.compare_ch9_prio == 3'h1);
    endproperty
    a_min_level: assert property (p_min_level)
        else $error("code 001 did not give level 1");

    property p_time_field;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_TIME_MEASURE)
            |=> (prio_out.time_measure_unit_prio == $past(reg_wdata[6:4]));
    endproperty
    a_time_field: assert property (p_time_field)
        else $error("time measure field misplaced");

    property p_uart3_fields;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_UART3_GROUP)
            |=> (prio_out.uart3_transmit_prio == $past(reg_wdata[14:12])
                && prio_out.uart3_receive_prio == $past(reg_wdata[10:8])
                && prio_out.uart3_error_prio == $past(reg_wdata[6:4]));
    endproperty
    a_uart3_fields: assert property (p_uart3_fields)
        else $error("uart3 fields misplaced");

    property p_uart4err_field;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_UART4ERR_USB_I2C3)
            |=> (prio_out.uart4_error_prio == $past(reg_wdata[14:12]));
    endproperty
    a_uart4err_field: assert property (p_uart4err_field)
        else $error("uart4 error field misplaced");

    property p_i2c3_fields;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_UART4ERR_USB_I2C3)
            |=> (prio_out.i2c3_master_event_prio == $past(reg_wdata[6:4])
                && prio_out.i2c3_slave_event_prio == $past(reg_wdata[2:0]));
    endproperty
    a_i2c3_fields: assert property (p_i2c3_fields)
        else $error("i2c3 fields misplaced");

    property p_spi3_fields;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_SPI3_UART4)
            |=> (prio_out.spi3_event_prio == $past(reg_wdata[14:12])
                && prio_out.spi3_fault_prio == $past(reg_wdata[10:8]));
    endproperty
    a_spi3_fields: assert property (p_spi3_fields)
        else $error("spi3 fields misplaced");

    property p_uart4_fields;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_SPI3_UART4)
            |=> (prio_out.uart4_transmit_prio == $past(reg_wdata[6:4])
                && prio_out.uart4_receive_prio == $past(reg_wdata[2:0]));
    endproperty
    a_uart4_fields: assert property (p_uart4_fields)
        else $error("uart4 fields misplaced");

    property p_capture_fields;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr == `IPR_OFF_CAPTURE9_COMPARE9)
            |=> (prio_out.capture_ch9_prio == $past(reg_wdata[6:4])
                && prio_out.compare_ch9_prio == $past(reg_wdata[2:0]));
    endproperty
    a_capture_fields: assert property (p_capture_fields)
        else $error("channel 9 fields misplaced");

    property p_unmapped_write;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_write && reg_addr > `IPR_OFF_CAPTURE9_COMPARE9)
            |=> $stable(prio_q);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("write to unmapped offset changed a field");

    property p_reg19_unimpl;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_read && reg_addr == `IPR_OFF_TIME_MEASURE)
            |=> (reg_rdata[15:7] == 9'h000 && reg_rdata[3:0] == 4'h0);
    endproperty
    a_reg19_unimpl: assert property (p_reg19_unimpl)
        else $error("register 19 reserved bits nonzero");

    property p_gap_bits;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_read && reg_addr >= `IPR_OFF_UART3_GROUP
            && reg_addr <= `IPR_OFF_SPI3_UART4)
            |=> (!reg_rdata[15] && !reg_rdata[11] && !reg_rdata[7]);
    endproperty
    a_gap_bits: assert property (p_gap_bits)
        else $error("gap bits between fields read nonzero");

    property p_reg20_low;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_read && reg_addr == `IPR_OFF_UART3_GROUP)
            |=> (reg_rdata[3:0] == 4'h0);
    endproperty
    a_reg20_low: assert property (p_reg20_low)
        else $error("register 20 low bits nonzero");

    property p_unmapped_read;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_read && reg_addr > `IPR_OFF_CAPTURE9_COMPARE9)
            |=> (reg_rdata == 16'h0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped offset read nonzero");

    property p_lvd_quiet;
        @(posedge sys_clk) disable iff (sys_rst)
        (prio_q.low_voltage_detect_prio == `IPR_LEVEL_OFF)
            |-> !src_request[14];
    endproperty
    a_lvd_quiet: assert property (p_lvd_quiet)
        else $error("disabled low-voltage source still requests");
endmodule

/* verif/tb.sv */
// Self-checking bench for the interrupt priority register bank
`timescale 1ns/1ps
module tb;
import ipr_pkg::*;
    localparam logic [15:0] MSK [6] = '{16'h0007, 16'h0070, 16'h7770,
        16'h7777, 16'h7777, 16'h0077};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    ipr_flags_type src_flags = '0;
    ipr_prio_type prio_out;
    logic [14:0] src_request;
    int seed = 45055;
    int bad_count = 0;
    int n_tests = 0;
    logic [15:0] mdl [6];
    logic [15:0] seen [6];
    logic [15:0] exp_q [$];
    logic rd_q = 1'b0;
    ipr_prio_type exp_p;
    logic [14:0] exp_r;
    logic [31:0] x;

    ipr_bank ipr_bank_i (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .src_flags(src_flags),
        .prio_out(prio_out),
        .src_request(src_request)
    );

    always #2.5 sys_clk = ~sys_clk;

    task automatic check(input string name, input logic [44:0] got,
        input logic [44:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One bus cycle; the model follows the write at the edge that drives it, one edge before the bank takes it
    task automatic acc(input logic w, input logic r, input logic [3:0] a,
        input logic [15:0] d);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (w && a < 4'h6)
            mdl[a[2:0]] <= d & MSK[a[2:0]];
        if (r)
            exp_q.push_back(a < 4'h6 ? mdl[a[2:0]] : 16'h0000);
        @(posedge sys_clk);
    endtask

    task automatic do_reset;
        for (int i = 0; i < 6; i++)
            mdl[i] = MSK[i] & 16'h4444;
        sys_rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
    endtask

    // Flags toggle at random so gating is seen with every code
    always @(posedge sys_clk)
    begin
        rd_q <= reg_read;
        seen <= mdl;
        src_flags.pending <= 15'($random(seed));
    end

    always @(negedge sys_clk)
    begin
        if (rd_q)
            check("reg_rdata", 45'(reg_rdata), 45'(exp_q.pop_front()));
        if (!sys_rst)
        begin
            exp_p = {seen[0][2:0], seen[1][6:4], seen[2][14:12],
                seen[2][10:8], seen[2][6:4], seen[3][14:12], seen[3][10:8],
                seen[3][6:4], seen[3][2:0], seen[4][14:12], seen[4][10:8],
                seen[4][6:4], seen[4][2:0], seen[5][6:4], seen[5][2:0]};
            for (int i = 0; i < 15; i++)
                exp_r[i] = src_flags.pending[i] && exp_p[3*i +: 3] != 3'h0;
            check("prio_out", 45'(prio_out), 45'(exp_p));
            check("src_request", 45'(src_request), 45'(exp_r));
        end
    end

    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        do_reset();
        // Reset pattern, then the unmapped offsets
        for (int a = 0; a < 16; a++)
            acc(1'b0, 1'b1, 4'(a), 16'h0000);
        // Every code in every field, reserved bits set, read back at once
        for (int c = 0; c < 8; c++)
            for (int a = 0; a < 6; a++)
            begin
                acc(1'b1, 1'b0, 4'(a), {4{1'b1, 3'(c)}});
                acc(1'b0, 1'b1, 4'(a), 16'h0000);
            end
        // Writes to unmapped offsets must leave the bank untouched
        for (int a = 6; a < 16; a++)
            acc(1'b1, 1'b0, 4'(a), 16'hFFFF);
        for (int a = 0; a < 6; a++)
            acc(1'b0, 1'b1, 4'(a), 16'h0000);
        repeat (300)
        begin
            x = $random(seed);
            acc(x[16], ~x[16] & x[17], x[23:20], x[15:0]);
        end
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        // Reset in mid-run restores level 4 everywhere
        do_reset();
        for (int a = 0; a < 6; a++)
            acc(1'b0, 1'b1, 4'(a), 16'h0000);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        acc(1'b0, 1'b0, 4'h0, 16'h0000);
        tally_and_finish();
    end
endmodule
